//--- rtl/sfrm_read_mapper.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
//Contract
// RULE1: a mapped window read first sends the programmable 8-bit read opcode.
// RULE2: the opcode goes out on one or four lanes per its lane width.
// RULE3: four option bytes, three down to zero, are held and can be sent.
// RULE4: option enable selects none, byte three, three-two, three-one, or all.
// RULE5: a 3-bit dummy count sets 0 to 7 dummy cycles before data.
// RULE6: dummy cycles only while dummy insert enable is set; else none.
// RULE7: dummy phase uses one or four lanes per the dummy lane width.
// RULE8: read data is received on one or four lanes per data lane width.
// RULE9: address goes out as 24 or 32 bits per the address format field.
// RULE10: option enable codes are 0x8, 0xC, 0xE and 0xF.
// RULE11: order opcode, address, options, dummy, data; skip disabled ones.
// RULE12: the flash treats the sequence as one read and answers after dummies.
module sfrm_read_mapper #(
	parameter int unsigned SCK_HALF = sfrm_pkg::SCK_HALF_CYC,
	parameter int unsigned CS_HIGH = sfrm_pkg::CS_HIGH_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfrm_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic map_req,
	input wire logic [31:0] map_addr,
	output logic map_ack,
	output logic [31:0] map_rdata,
	output logic flash_sck,
	output logic flash_cs_n,
	output logic [3:0] flash_io_out,
	output logic [3:0] flash_io_oe,
	input wire logic [3:0] flash_io_in
);
	import sfrm_pkg::*;

	localparam logic [3:0] CS_HIGH_M = 4'(CS_HIGH);

	typedef struct packed {
		sfrm_state_t state;
		logic cs_n;
		logic launched;
		logic start;
		logic [3:0] cs_cnt;
		logic [31:0] addr;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] count;
		logic [31:0] opcode_reg;
		logic [31:0] enable_reg;
		logic [31:0] option_reg;
		logic [31:0] dummy_reg;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sfrm_top_t;

	localparam sfrm_top_t TOP_RST = '{
		state: ST_IDLE,
		cs_n: 1'b1,
		launched: 1'b0,
		start: 1'b0,
		cs_cnt: 4'h0,
		addr: 32'h0000_0000,
		ack: 1'b0,
		rdata: 32'h0000_0000,
		count: 32'h0000_0000,
		opcode_reg: RST_OPCODE,
		enable_reg: RST_ENABLE,
		option_reg: RST_OPTION,
		dummy_reg: RST_DUMMY,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h0000_0000
	};

	sfrm_top_t st_reg;
	sfrm_top_t st_next;

	sfrm_shmode_t sh_mode;
	logic sh_quad;
	logic [31:0] sh_data;
	logic [5:0] sh_ncyc;
	logic sh_done;
	logic [31:0] sh_rx;

	// number of option bytes sent, counted from byte three
	function automatic logic [2:0] opt_bytes(input logic [3:0] en);
		case (en)
			OPT_3: return 3'h1; // RULE10
			OPT_32: return 3'h2; // RULE10
			OPT_321: return 3'h3; // RULE10
			OPT_3210: return 3'h4; // RULE10
			default: return 3'h0; // RULE4
		endcase
	endfunction : opt_bytes

	function automatic logic phase_on(input sfrm_state_t s,
		input logic [31:0] en, input logic [31:0] dm);
		case (s)
			ST_ADDR: return en[EN_AFMT_LSB +: 4] != AFMT_NONE;
			ST_OPT: return opt_bytes(en[EN_OPT_LSB +: 4]) != 3'h0; // RULE4
			ST_DUMMY: return en[EN_DME_BIT] &&
				(dm[DM_CNT_LSB +: 3] != 3'h0); // RULE6
			default: return 1'b1;
		endcase
	endfunction : phase_on

	function automatic sfrm_state_t next_phase(input sfrm_state_t cur,
		input logic [31:0] en, input logic [31:0] dm);
		logic past_addr;
		logic past_opt;
		past_addr = (cur == ST_CMD) || (cur == ST_ADDR);
		past_opt = past_addr || (cur == ST_OPT);
		if (cur == ST_CMD && phase_on(ST_ADDR, en, dm)) begin
			return ST_ADDR; // RULE11
		end else if (past_addr && phase_on(ST_OPT, en, dm)) begin
			return ST_OPT; // RULE11
		end else if (past_opt && phase_on(ST_DUMMY, en, dm)) begin
			return ST_DUMMY; // RULE11
		end else if (cur != ST_DATA) begin
			return ST_DATA; // RULE11
		end else begin
			return ST_DONE;
		end
	endfunction : next_phase

	// index 7 marks an unmapped or misaligned address
	function automatic logic [2:0] reg_index(input logic [11:0] a);
		case (a)
			OFS_OPCODE: return 3'h0;
			OFS_ENABLE: return 3'h1;
			OFS_OPTION: return 3'h2;
			OFS_DUMMY: return 3'h3;
			OFS_STATUS: return 3'h4;
			OFS_LASTADDR: return 3'h5;
			OFS_COUNT: return 3'h6;
			default: return 3'h7;
		endcase
	endfunction : reg_index

	always_comb begin
		logic busy;
		logic setup;
		logic access;
		logic err;
		logic [2:0] idx;
		logic [31:0] rd;
		logic [31:0] status;
		logic aq;
		rd = 32'h0000_0000;
		err = 1'b0;
		busy = st_reg.state != ST_IDLE;
		setup = psel && !penable;
		access = psel && penable && st_reg.pready;
		idx = reg_index(paddr);
		status = 32'h0000_0000;
		status[ST_BUSY_BIT] = busy;
		status[ST_STATE_LSB +: 3] = st_reg.state;
		aq = is_quad(st_reg.enable_reg[EN_ALW_LSB +: 2]);
		st_next = st_reg;
		st_next.start = 1'b0;
		st_next.ack = 1'b0;

		// phase set-up seen by the shifter when start is high
		sh_mode = SH_TX;
		sh_quad = 1'b0;
		sh_data = 32'h0000_0000;
		sh_ncyc = 6'h00;
		case (st_reg.state)
			ST_CMD: begin
				sh_quad = is_quad(st_reg.enable_reg[EN_OLW_LSB +: 2]); // RULE2
				sh_data = {st_reg.opcode_reg[7:0], 24'h00_0000}; // RULE1
				sh_ncyc = sck_cycles(OPC_BITS, sh_quad); // RULE2
			end
			ST_ADDR: begin
				sh_quad = aq;
				if (st_reg.enable_reg[EN_AFMT_LSB +: 4] == AFMT_32) begin
					sh_data = st_reg.addr; // RULE9
					sh_ncyc = sck_cycles(ADDR32_BITS, aq); // RULE9
				end else begin
					sh_data = {st_reg.addr[23:0], 8'h00}; // RULE9
					sh_ncyc = sck_cycles(ADDR24_BITS, aq); // RULE9
				end
			end
			ST_OPT: begin
				// byte three sits on top, so it leaves first
				sh_quad = aq;
				sh_data = st_reg.option_reg; // RULE3
				sh_ncyc = sck_cycles({opt_bytes(
					st_reg.enable_reg[EN_OPT_LSB +: 4]), 3'h0}, aq); // RULE4
			end
			ST_DUMMY: begin
				sh_mode = SH_DUMMY;
				sh_quad = is_quad(st_reg.dummy_reg[DM_LW_LSB +: 2]); // RULE7
				sh_ncyc = {3'h0, st_reg.dummy_reg[DM_CNT_LSB +: 3]}; // RULE5
			end
			ST_DATA: begin
				sh_mode = SH_RX;
				sh_quad = is_quad(st_reg.enable_reg[EN_DLW_LSB +: 2]); // RULE8
				sh_ncyc = sck_cycles(DATA_BITS, sh_quad); // RULE8
			end
			default: begin
				sh_mode = SH_TX;
			end
		endcase

		if (st_reg.cs_cnt != 4'h0) begin
			st_next.cs_cnt = st_reg.cs_cnt - 4'h1;
		end

		case (st_reg.state)
			ST_IDLE: begin
				// ack still high means the requester has not yet let go
				if (map_req && !st_reg.ack && st_reg.cs_cnt == 4'h0) begin
					st_next.addr = map_addr;
					st_next.cs_n = 1'b0;
					st_next.launched = 1'b0;
					st_next.state = ST_CMD; // RULE1
				end
			end
			ST_CMD, ST_ADDR, ST_OPT, ST_DUMMY, ST_DATA: begin
				if (!st_reg.launched) begin
					st_next.start = 1'b1;
					st_next.launched = 1'b1;
				end else if (sh_done) begin
					st_next.launched = 1'b0;
					st_next.state = next_phase(st_reg.state,
						st_reg.enable_reg, st_reg.dummy_reg); // RULE11
				end
			end
			ST_DONE: begin
				// first byte off the wire lands in the low lane
				st_next.rdata = {sh_rx[7:0], sh_rx[15:8], sh_rx[23:16],
					sh_rx[31:24]}; // RULE8
				st_next.ack = 1'b1;
				st_next.cs_n = 1'b1;
				st_next.cs_cnt = CS_HIGH_M;
				st_next.count = st_reg.count + 32'h0000_0001;
				st_next.state = ST_IDLE;
			end
			default: begin
				st_next.state = ST_IDLE;
				st_next.cs_n = 1'b1;
			end
		endcase

		// APB slave, no wait states; answer prepared in the setup cycle
		case (idx)
			3'h0: rd = st_reg.opcode_reg;
			3'h1: rd = st_reg.enable_reg;
			3'h2: rd = st_reg.option_reg;
			3'h3: rd = st_reg.dummy_reg;
			3'h4: rd = status;
			3'h5: rd = st_reg.addr;
			3'h6: rd = st_reg.count;
			default: rd = 32'h0000_0000;
		endcase
		// config must not change under a running frame
		err = (idx == 3'h7) || (pwrite && (idx > 3'h3 || busy));
		st_next.pready = setup;
		st_next.pslverr = setup ? err : 1'b0;
		if (setup) begin
			st_next.prdata = (pwrite || err) ? 32'h0000_0000 : rd;
		end
		if (access && pwrite && !st_reg.pslverr) begin
			case (idx)
				3'h0: st_next.opcode_reg = pwdata & MASK_OPCODE; // RULE1
				3'h1: st_next.enable_reg = pwdata & MASK_ENABLE; // RULE4
				3'h2: st_next.option_reg = pwdata & MASK_OPTION; // RULE3
				3'h3: st_next.dummy_reg = pwdata & MASK_DUMMY; // RULE5
				default: st_next.count = st_reg.count;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= TOP_RST;
		end else if (pce) begin
			st_reg <= st_next;
		end
	end

	sfrm_lane_shifter #(
		.HALF(SCK_HALF)
	) u_shifter (
		.pclk(pclk),
		.presetn(presetn),
		.ce(pce),
		.start(st_reg.start),
		.mode(sh_mode),
		.quad(sh_quad),
		.tx_data(sh_data),
		.ncyc(sh_ncyc),
		.done(sh_done),
		.rx_data(sh_rx),
		.sck(flash_sck),
		.io_out(flash_io_out),
		.io_oe(flash_io_oe),
		.io_in(flash_io_in)
	);

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign map_ack = st_reg.ack;
	assign map_rdata = st_reg.rdata;
	assign flash_cs_n = st_reg.cs_n;
endmodule : sfrm_read_mapper

//--- rtl/sfrm_pkg.sv
package sfrm_pkg;
	// timing
	localparam int unsigned PCLK_NS = 40;
	localparam int unsigned SCK_PERIOD_NS = 320;
	localparam int unsigned SCK_HALF_CYC = SCK_PERIOD_NS / (2 * PCLK_NS);
	localparam int unsigned CS_HIGH_NS = 80;
	localparam int unsigned CS_HIGH_CYC = (CS_HIGH_NS + PCLK_NS - 1) / PCLK_NS;

	// register map
	localparam int unsigned APB_AW = 12;
	localparam logic [11:0] OFS_OPCODE = 12'h000;
	localparam logic [11:0] OFS_ENABLE = 12'h004;
	localparam logic [11:0] OFS_OPTION = 12'h008;
	localparam logic [11:0] OFS_DUMMY = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_LASTADDR = 12'h014;
	localparam logic [11:0] OFS_COUNT = 12'h018;

	// field positions
	localparam int unsigned EN_OLW_LSB = 0;
	localparam int unsigned EN_OPT_LSB = 4;
	localparam int unsigned EN_AFMT_LSB = 8;
	localparam int unsigned EN_ALW_LSB = 12;
	localparam int unsigned EN_DME_BIT = 14;
	localparam int unsigned EN_DLW_LSB = 16;
	localparam int unsigned DM_CNT_LSB = 0;
	localparam int unsigned DM_LW_LSB = 16;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_STATE_LSB = 1;

	// write masks and reset values
	localparam logic [31:0] MASK_OPCODE = 32'h0000_00FF;
	localparam logic [31:0] MASK_ENABLE = 32'h0003_7FF3;
	localparam logic [31:0] MASK_OPTION = 32'hFFFF_FFFF;
	localparam logic [31:0] MASK_DUMMY = 32'h0003_0007;
	localparam logic [31:0] RST_OPCODE = 32'h0000_0003;
	localparam logic [31:0] RST_ENABLE = 32'h0000_0700;
	localparam logic [31:0] RST_OPTION = 32'h0000_0000;
	localparam logic [31:0] RST_DUMMY = 32'h0000_0000;

	// encodings
	localparam logic [1:0] LW_1 = 2'h0;
	localparam logic [1:0] LW_4 = 2'h2;
	localparam logic [3:0] AFMT_NONE = 4'h0;
	localparam logic [3:0] AFMT_24 = 4'h7;
	localparam logic [3:0] AFMT_32 = 4'hF;
	localparam logic [3:0] OPT_3 = 4'h8;
	localparam logic [3:0] OPT_32 = 4'hC;
	localparam logic [3:0] OPT_321 = 4'hE;
	localparam logic [3:0] OPT_3210 = 4'hF;

	// serial bit counts
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR24_BITS = 6'h18;
	localparam logic [5:0] ADDR32_BITS = 6'h20;
	localparam logic [5:0] DATA_BITS = 6'h20;

	typedef enum logic [1:0] {
		SH_TX = 2'h0,
		SH_DUMMY = 2'h1,
		SH_RX = 2'h2
	} sfrm_shmode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD = 3'h1,
		ST_ADDR = 3'h3,
		ST_OPT = 3'h2,
		ST_DUMMY = 3'h6,
		ST_DATA = 3'h7,
		ST_DONE = 3'h5
	} sfrm_state_t;

	function automatic logic is_quad(input logic [1:0] lw);
		return lw == LW_4;
	endfunction : is_quad

	// serial clocks needed for a bit count on 1 or 4 lanes
	function automatic logic [5:0] sck_cycles(input logic [5:0] bits,
		input logic quad);
		return quad ? {2'h0, bits[5:2]} : bits;
	endfunction : sck_cycles
endpackage : sfrm_pkg

//--- rtl/sfrm_lane_shifter.sv
`timescale 1ns/1ns
module sfrm_lane_shifter #(
	parameter int unsigned HALF = sfrm_pkg::SCK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire sfrm_pkg::sfrm_shmode_t mode,
	input wire logic quad,
	input wire logic [31:0] tx_data,
	input wire logic [5:0] ncyc,
	output logic done,
	output logic [31:0] rx_data,
	output logic sck,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic [3:0] io_in
);
	import sfrm_pkg::*;

	localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

	typedef struct packed {
		logic busy;
		logic done;
		logic sck;
		logic [7:0] half;
		logic [5:0] left;
		logic [31:0] sr;
		logic quad;
		sfrm_shmode_t mode;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [3:0] sync1;
		logic [3:0] sync2;
	} sfrm_sh_t;

	sfrm_sh_t sh_reg;
	sfrm_sh_t sh_next;

	always_comb begin
		logic [31:0] shifted;
		shifted = '0;
		sh_next = sh_reg;
		sh_next.done = 1'b0;
		sh_next.sync1 = io_in;
		sh_next.sync2 = sh_reg.sync1;
		if (start && !sh_reg.busy) begin
			sh_next.busy = (ncyc != 6'h00);
			sh_next.done = (ncyc == 6'h00);
			sh_next.sck = 1'b0;
			sh_next.half = 8'h00;
			sh_next.left = ncyc;
			sh_next.sr = tx_data;
			sh_next.quad = quad;
			sh_next.mode = mode;
			// receive leaves every lane to the flash
			if (mode == SH_RX) begin
				sh_next.io_oe = 4'h0;
			end else begin
				sh_next.io_oe = quad ? 4'hF : 4'h1;
			end
			if (mode == SH_TX) begin
				sh_next.io_out = quad ? tx_data[31:28] : {3'h0, tx_data[31]};
			end else begin
				sh_next.io_out = 4'h0;
			end
		end else if (sh_reg.busy) begin
			if (sh_reg.half != HALF_M1) begin
				sh_next.half = sh_reg.half + 8'h01;
			end else begin
				sh_next.half = 8'h00;
				if (!sh_reg.sck) begin
					sh_next.sck = 1'b1;
					// sample on the rising edge, flash shifts on falling
					if (sh_reg.mode == SH_RX) begin
						if (sh_reg.quad) begin
							sh_next.sr = {sh_reg.sr[27:0], sh_reg.sync2};
						end else begin
							sh_next.sr = {sh_reg.sr[30:0], sh_reg.sync2[1]};
						end
					end
				end else begin
					sh_next.sck = 1'b0;
					sh_next.left = sh_reg.left - 6'h01;
					if (sh_reg.mode == SH_TX) begin
						shifted = sh_reg.quad ? {sh_reg.sr[27:0], 4'h0}
							: {sh_reg.sr[30:0], 1'b0};
						sh_next.sr = shifted;
						sh_next.io_out = sh_reg.quad ? shifted[31:28]
							: {3'h0, shifted[31]};
					end
					if (sh_reg.left == 6'h01) begin
						sh_next.busy = 1'b0;
						sh_next.done = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg <= '0;
		end else if (ce) begin
			sh_reg <= sh_next;
		end
	end

	assign done = sh_reg.done;
	assign rx_data = sh_reg.sr;
	assign sck = sh_reg.sck;
	assign io_out = sh_reg.io_out;
	assign io_oe = sh_reg.io_oe;
endmodule : sfrm_lane_shifter

//--- tb/sfrm_read_mapper_monitor.sv
`timescale 1ns/1ns
module sfrm_read_mapper_monitor #(
	parameter int unsigned SCK_HALF = 4,
	parameter int unsigned CS_HIGH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic map_req,
	input wire logic map_ack,
	input wire logic [31:0] map_rdata,
	input wire logic flash_sck,
	input wire logic flash_cs_n,
	input wire logic [3:0] flash_io_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	// a frozen clock enable stretches every timing, so checks pause
	default disable iff (!presetn || !pce);

	// zero wait states promised for every register access
	apb_answer_a: assert property ((psel && !penable) |=> pready && penable)
		else $error("no ready in access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	ack_pulse_a: assert property (map_ack |=> !map_ack)
		else $error("ack longer than one cycle");
	ack_deselect_a: assert property (map_ack |-> $rose(flash_cs_n))
		else $error("ack not with deselect");
	select_cause_a: assert property ($fell(flash_cs_n) |-> $past(map_req))
		else $error("select without request");
	opcode_first_a: assert property ($fell(flash_cs_n) |->
		##[1:3] flash_io_oe[0])
		else $error("opcode lane not driven");
	// sck high time equals SCK_HALF at the default of four
	sck_high_a: assert property ($rose(flash_sck) |=>
		flash_sck[*3] ##1 !flash_sck)
		else $error("sck high time wrong");
	idle_lines_a: assert property (flash_cs_n |->
		!flash_sck && flash_io_oe == 4'h0)
		else $error("lines busy while deselected");
	deselect_gap_a: assert property ($rose(flash_cs_n) |=> flash_cs_n[*2])
		else $error("deselect too short");
	rdata_hold_a: assert property (!map_ack |-> $stable(map_rdata))
		else $error("read word moved without ack");
	cover property (map_ack);
	cover property (pslverr);
	cover property ($rose(flash_sck) && flash_io_oe == 4'hF);
endmodule : sfrm_read_mapper_monitor

bind sfrm_read_mapper sfrm_read_mapper_monitor #(.SCK_HALF(SCK_HALF),
	.CS_HIGH(CS_HIGH)) u_sfrm_read_mapper_monitor (.pclk(pclk),
	.presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
	.pready(pready),
	.pslverr(pslverr), .map_req(map_req), .map_ack(map_ack),
	.map_rdata(map_rdata), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
	.flash_io_oe(flash_io_oe));

//--- tb/sfrm_flash_model.sv
`timescale 1ns/1ns
module sfrm_flash_model (
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_out,
	input wire logic quad,
	input wire logic [7:0] hdr,
	input wire logic [31:0] word,
	output logic [3:0] io_in,
	output logic [127:0] cap,
	output logic [7:0] nrise
);
	int k;
	initial begin
		io_in = 4'h5;
		nrise = 8'h00;
	end
	// command part shifts in at rising sck, one or four lanes
	always @(negedge cs_n or posedge sck) begin
		if (!sck) begin
			nrise <= 8'h00;
			cap <= '0;
		end else begin
			if (nrise < hdr)
				cap <= quad ? {cap[123:0], io_out}
					: {cap[126:0], io_out[0]};
			nrise <= nrise + 8'h01;
		end
	end
	// released lanes toggle so a stale value is never read as data
	always @(negedge sck or posedge cs_n) begin
		k = int'(nrise) - int'(hdr);
		if (!cs_n && k >= 0 && quad && k < 8)
			io_in <= word[8 * (k / 2) + 4 * (1 - k % 2) +: 4];
		else if (!cs_n && k >= 0 && !quad && k < 32)
			io_in <= {~io_in[3:2], word[8 * (k / 8) + 7 - k % 8], ~io_in[0]};
		else
			io_in <= ~io_in;
	end
endmodule : sfrm_flash_model

//--- tb/sfrm_read_mapper_test.sv
`timescale 1ns/1ns
module sfrm_read_mapper_test;
	import sfrm_pkg::*;
	typedef struct {
		logic [7:0] op;
		logic [31:0] en;
		logic [31:0] dm;
		logic [31:0] a;
		logic [31:0] w;
	} sfrm_row_t;
	localparam logic [31:0] OPT_VAL = 32'hA1B2_C3D4;
	localparam logic [31:0] RST_VAL [4] = '{32'h3, 32'h700, 32'h0, 32'h0};
	logic pclk, presetn, pce, psel, penable, pwrite, map_req, map_ack;
	logic pready, pslverr, flash_sck, flash_cs_n, quad;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, map_addr, map_rdata, got, fword;
	logic [3:0] flash_io_out, flash_io_oe, flash_io_in;
	logic [7:0] hdr, nrise;
	logic [127:0] cap, h, mask;
	int bad_count, checked, ab, n, dc, db, hb, lw;
	sfrm_row_t rows [6];

	sfrm_read_mapper u_sfrm_read_mapper (.pclk(pclk), .presetn(presetn),
		.pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .map_req(map_req), .map_addr(map_addr),
		.map_ack(map_ack), .map_rdata(map_rdata), .flash_sck(flash_sck),
		.flash_cs_n(flash_cs_n), .flash_io_out(flash_io_out),
		.flash_io_oe(flash_io_oe), .flash_io_in(flash_io_in));
	sfrm_flash_model u_sfrm_flash_model (.cs_n(flash_cs_n), .sck(flash_sck),
		.io_out(flash_io_out), .quad(quad), .hdr(hdr), .word(fword),
		.io_in(flash_io_in), .cap(cap), .nrise(nrise));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [127:0] seen,
		input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] xq, input logic xe);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk("pready", pready, 1'b1);
		chk("pslverr", pslverr, xe);
		if (!w)
			chk("prdata", prdata, xq);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : acc

	task automatic map_go(input logic [31:0] a);
		map_req <= 1'b1;
		map_addr <= a;
		@(posedge pclk);
	endtask : map_go

	task automatic map_wait();
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (map_ack !== 1'b1 && k < 4000);
		chk("map_ack", map_ack, 1'b1);
		got = map_rdata;
		map_req <= 1'b0;
		@(posedge pclk);
	endtask : map_wait

	task automatic final_report();
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	initial begin
		#2400000;
		bad_count++;
		final_report();
	end

	initial begin
		bad_count = 0;
		checked = 0;
		{presetn, psel, penable, pwrite, map_req, quad} = '0;
		pce = 1'b1;
		paddr = '0;
		pwdata = '0;
		map_addr = '0;
		fword = '0;
		hdr = 8'h08;
		rows[0] = '{8'h03, 32'h0700, 32'h0, 32'h0012_3456, 32'h8001_7EA5};
		rows[1] = '{8'h0B, 32'h4F80, 32'h3, 32'h89AB_CDEF, 32'h1234_5678};
		rows[2] = '{8'hEB, 32'h267C2, 32'h20007, 32'h00FE_DCBA, 32'hDEAD_BEEF};
		rows[3] = '{8'h6B, 32'h22FE2, 32'h20005, 32'h7654_3210, 32'h0F1E_2D3C};
		rows[4] = '{8'h3B, 32'h47F0, 32'h0, 32'h0055_AA00, 32'hC3C3_3C3C};
		rows[5] = '{8'h6C, 32'h26002, 32'h20002, 32'h0033_4455, 32'h9A8B_7C6D};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(1'b1, OFS_OPTION, OPT_VAL, '0, 1'b0);
		acc(1'b0, OFS_OPTION, '0, OPT_VAL, 1'b0);
		foreach (rows[i]) begin
			acc(1'b1, OFS_OPCODE, {24'h0, rows[i].op}, '0, 1'b0);
			acc(1'b1, OFS_ENABLE, rows[i].en, '0, 1'b0);
			acc(1'b1, OFS_DUMMY, rows[i].dm, '0, 1'b0);
			lw = (rows[i].en[1:0] == 2'h2) ? 4 : 1;
			case (rows[i].en[11:8])
				AFMT_NONE: ab = 0;
				AFMT_32: ab = 32;
				default: ab = 24;
			endcase
			case (rows[i].en[7:4])
				OPT_3: n = 1;
				OPT_32: n = 2;
				OPT_321: n = 3;
				OPT_3210: n = 4;
				default: n = 0;
			endcase
			dc = rows[i].en[14] ? int'(rows[i].dm[2:0]) : 0;
			h = 128'(rows[i].op);
			h = (h << ab) | (128'(rows[i].a) & ((128'h1 << ab) - 128'h1));
			for (int j = 0; j < n; j++)
				h = (h << 8) | 128'(OPT_VAL[31 - 8 * j -: 8]);
			db = dc * lw;
			hb = 8 + ab + 8 * n;
			mask = (128'h1 << (hb + db)) - 128'h1;
			quad <= (lw == 4);
			hdr <= 8'(hb / lw + dc);
			fword <= rows[i].w;
			map_go(rows[i].a);
			map_wait();
			chk("map_rdata", got, rows[i].w);
			chk("sck count", nrise, hdr + 8'(32 / lw));
			chk("header", cap & mask, h << db);
		end
		acc(1'b0, OFS_COUNT, '0, 32'h6, 1'b0);
		acc(1'b0, 12'h01C, '0, '0, 1'b1);
		acc(1'b1, OFS_STATUS, 32'hFF, '0, 1'b1);
		// a write landing mid-frame must be refused and leave config intact
		map_go(32'h0000_0100);
		acc(1'b1, OFS_OPCODE, 32'hFF, '0, 1'b1);
		map_wait();
		acc(1'b0, OFS_OPCODE, '0, 32'h6C, 1'b0);
		acc(1'b0, OFS_LASTADDR, '0, 32'h0000_0100, 1'b0);
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int j = 0; j < 4; j++)
			acc(1'b0, 12'(4 * j), '0, RST_VAL[j], 1'b0);
		acc(1'b0, OFS_COUNT, '0, 32'h0, 1'b0);
		// clock enable low in mid-frame must freeze every pin
		quad <= 1'b0;
		hdr <= 8'h20;
		fword <= 32'h5A5A_0FF0;
		map_go(32'h0000_0040);
		repeat (40) @(posedge pclk);
		pce <= 1'b0;
		@(posedge pclk);
		h = 128'({flash_sck, flash_cs_n, flash_io_out, flash_io_oe});
		repeat (30) @(posedge pclk);
		chk("frozen pins", {flash_sck, flash_cs_n, flash_io_out, flash_io_oe}, h);
		pce <= 1'b1;
		map_wait();
		chk("map_rdata", got, 32'h5A5A_0FF0);
		acc(1'b0, OFS_COUNT, '0, 32'h1, 1'b0);
		final_report();
	end
endmodule : sfrm_read_mapper_test
